// ==== pae_channel.sv ====
`timescale 1ns/1ns
module pae_channel (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic secTick,
  input wire logic evalTick,
  input wire logic rearm,
  input wire logic ack,
  input pae_pkg::pae_cfg_t cfg,
  input pae_pkg::pae_lim_t lim,
  input pae_pkg::pae_src_t src,
  output logic active
);
  localparam int VAL_W_L = pae_pkg::VAL_W;
  logic signed [17:0] hiLvl;
  logic signed [17:0] loLvl;
  logic signed [17:0] meas;
  logic signed [17:0] db;
  logic signed [17:0] delta;
  logic hiTrip;
  logic loTrip;
  logic hiClear;
  logic loClear;
  logic trip;
  logic normal;
  logic legal;
  logic signed [VAL_W_L-1:0] ref_q;
  logic signed [VAL_W_L-1:0] ref_d;
  logic [14:0] winCnt_q;
  logic [14:0] winCnt_d;
  logic [14:0] dlyCnt_q;
  logic [14:0] dlyCnt_d;
  logic [14:0] inhCnt_q;
  logic [14:0] inhCnt_d;
  logic inhibit_q;
  logic inhibit_d;
  logic cond_q;
  logic cond_d;
  logic acked_q;
  logic acked_d;
  logic active_d;

  always_comb begin
    meas = 18'(src.value);
    db = 18'($signed({1'b0, lim.deadband}));
    hiLvl = 18'(lim.upper);
    loLvl = 18'(lim.lower);
    if (cfg.kind == pae_pkg::PAE_TYPE_DEVIATION) begin
      hiLvl = 18'(src.setPoint) + 18'(lim.upper);
      loLvl = 18'(src.setPoint) - 18'(lim.lower);
    end
    if (cfg.kind == pae_pkg::PAE_TYPE_OUTPCT) begin
      meas = 18'(src.outPct);
    end
    delta = meas - 18'(ref_q);
    hiTrip = 1'b0;
    loTrip = 1'b0;
    hiClear = 1'b1;
    loClear = 1'b1;
    if (cfg.kind == pae_pkg::PAE_TYPE_RATE) begin
      hiTrip = delta > hiLvl;
      loTrip = -delta > hiLvl;
      hiClear = delta < hiLvl - db;
      loClear = -delta < hiLvl - db;
    end else begin
      hiTrip = meas > hiLvl;
      loTrip = meas < loLvl;
      hiClear = meas <= hiLvl - db;
      loClear = meas >= loLvl + db;
    end
    legal = (cfg.kind != pae_pkg::PAE_TYPE_OFF) && (src.isLoop ||
      (cfg.kind == pae_pkg::PAE_TYPE_PROCESS) ||
      (cfg.kind == pae_pkg::PAE_TYPE_RATE));
    unique case (cfg.side)
      pae_pkg::PAE_SIDE_UPPER: begin
        trip = hiTrip;
        normal = hiClear;
      end
      pae_pkg::PAE_SIDE_LOWER: begin
        trip = loTrip;
        normal = loClear;
      end
      pae_pkg::PAE_SIDE_BOTH: begin
        trip = hiTrip | loTrip;
        normal = hiClear & loClear;
      end
      default: begin
        trip = 1'b0;
        normal = 1'b1;
      end
    endcase
    trip = trip & legal;
  end

  always_comb begin
    ref_d = ref_q;
    winCnt_d = winCnt_q;
    dlyCnt_d = dlyCnt_q;
    inhCnt_d = inhCnt_q;
    inhibit_d = inhibit_q;
    cond_d = cond_q;
    acked_d = acked_q;
    active_d = active;
    if (ack && active) begin
      acked_d = 1'b1;
    end
    if (evalTick) begin
      if (secTick && cfg.kind == pae_pkg::PAE_TYPE_RATE) begin
        if (winCnt_q + 15'd1 >= lim.rateWindow * 15'd60) begin
          ref_d = src.value;
          winCnt_d = '0;
        end else begin
          winCnt_d = winCnt_q + 15'd1;
        end
      end
      if (inhibit_q && legal && normal && !trip) begin
        inhibit_d = 1'b0;
      end
      if (secTick && inhibit_q && lim.inhibitLimit != '0) begin
        inhCnt_d = inhCnt_q + 15'd1;
        if (inhCnt_d >= lim.inhibitLimit) begin
          inhibit_d = 1'b0;
        end
      end
      if (trip && !(cfg.inhibitEn && inhibit_q)) begin
        if (dlyCnt_q >= lim.onDelay) begin
          cond_d = 1'b1;
        end else if (secTick) begin
          dlyCnt_d = dlyCnt_q + 15'd1;
          if (dlyCnt_d >= lim.onDelay) begin
            cond_d = 1'b1;
          end
        end
      end else begin
        dlyCnt_d = '0;
        if (normal || !legal) begin
          cond_d = 1'b0;
        end
      end
      if (cond_d && !cond_q) begin
        active_d = 1'b1;
        acked_d = ack && active;
      end else if (!cond_d) begin
        if (!cfg.latching || acked_d || !legal) begin
          active_d = 1'b0;
          acked_d = 1'b0;
        end
      end
    end
    if (rearm) begin
      inhibit_d = 1'b1;
      inhCnt_d = '0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_q <= '0;
      winCnt_q <= '0;
      dlyCnt_q <= '0;
      inhCnt_q <= '0;
      inhibit_q <= 1'b1;
      cond_q <= 1'b0;
      acked_q <= 1'b0;
      active <= 1'b0;
    end else begin
      ref_q <= ref_d;
      winCnt_q <= winCnt_d;
      dlyCnt_q <= dlyCnt_d;
      inhCnt_q <= inhCnt_d;
      inhibit_q <= inhibit_d;
      cond_q <= cond_d;
      acked_q <= acked_d;
      active <= active_d;
    end
  end
endmodule

// ==== pae_checker.sv ====
`timescale 1ns/1ns
module pae_checker #(
  parameter int NUM_ALARMS = 30
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] doAlarmCfg,
  input wire logic [15:0] digitalOut,
  input wire logic [NUM_ALARMS-1:0] alarmActive
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after the address");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> !s_axi_bvalid ##1 !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after the transfer");
  a_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed while waiting");
  a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed while waiting");
  a_read_busy:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while busy");
  a_write_busy:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_do_masked:
    assert property ((digitalOut & ~doAlarmCfg & ~$past(doAlarmCfg)) == 16'h0)
    else $error("output driven that is not set up for alarms");
  a_do_needs_alarm:
    assert property (digitalOut != 16'h0 |-> alarmActive != '0 || $past(alarmActive) != '0)
    else $error("output on without an active alarm");
  a_do_quiet:
    assert property ((alarmActive == '0) [*2] |-> digitalOut == 16'h0)
    else $error("output still on after all alarms cleared");
endmodule

bind pae_top pae_checker #(.NUM_ALARMS(NUM_ALARMS)) u_checker (
  .core_clk(core_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .doAlarmCfg(doAlarmCfg),
  .digitalOut(digitalOut), .alarmActive(alarmActive)
);

// ==== pae_pkg.sv ====
package pae_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam int TICK_HZ = 1000;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int NUM_ALARMS = 30;
  localparam int NUM_INPUTS = 16;
  localparam int NUM_LOOPS = 8;
  localparam int VAL_W = 16;
  localparam int TIME_W = 15;
  localparam int MAX_SECONDS = 32760;
  localparam int SEL_W = 4;
  localparam int IDX_W = 5;
  localparam int DO_W = 4;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_ACK = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
  localparam logic [31:0] ADDR_INDEX = 32'h0000_000c;
  localparam logic [31:0] ADDR_CFG = 32'h0000_0010;
  localparam logic [31:0] ADDR_LEVELS = 32'h0000_0014;
  localparam logic [31:0] ADDR_DBDLY = 32'h0000_0018;
  localparam logic [31:0] ADDR_INHWIN = 32'h0000_001c;
  localparam logic [31:0] ADDR_COMMIT = 32'h0000_0020;
  localparam logic [31:0] ADDR_VAL = 32'h0000_0024;
  localparam logic [31:0] ADDR_SP = 32'h0000_0028;
  localparam logic [31:0] ADDR_OUTPCT = 32'h0000_002c;
  localparam logic [31:0] ADDR_ACTIVE = 32'h0000_0030;
  localparam int CTRL_ONLINE_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    PAE_TYPE_OFF = 3'b000,
    PAE_TYPE_PROCESS = 3'b001,
    PAE_TYPE_DEVIATION = 3'b010,
    PAE_TYPE_OUTPCT = 3'b011,
    PAE_TYPE_RATE = 3'b100
  } pae_type_t;

  typedef enum logic [1:0] {
    PAE_SIDE_NONE = 2'b00,
    PAE_SIDE_UPPER = 2'b01,
    PAE_SIDE_LOWER = 2'b10,
    PAE_SIDE_BOTH = 2'b11
  } pae_side_t;

  typedef struct packed {
    logic [SEL_W-1:0] srcSel;
    logic [DO_W-1:0] doSel;
    logic doEn;
    logic latching;
    logic inhibitEn;
    pae_side_t side;
    pae_type_t kind;
  } pae_cfg_t;

  typedef struct packed {
    logic signed [VAL_W-1:0] upper;
    logic signed [VAL_W-1:0] lower;
    logic [VAL_W-1:0] deadband;
    logic [TIME_W-1:0] onDelay;
    logic [TIME_W-1:0] inhibitLimit;
    logic [TIME_W-1:0] rateWindow;
  } pae_lim_t;

  typedef struct packed {
    logic signed [VAL_W-1:0] value;
    logic signed [VAL_W-1:0] setPoint;
    logic signed [VAL_W-1:0] outPct;
    logic isLoop;
  } pae_src_t;

  localparam int CFG_RESET = 0;
endpackage

// ==== pae_plant.sv ====
`timescale 1ns/1ns
module pae_plant #(
  parameter int NUM_INPUTS = 16
) (
  input wire logic core_clk,
  output pae_pkg::pae_src_t [NUM_INPUTS-1:0] srcIn,
  output logic remoteSilence,
  output logic [15:0] doAlarmCfg
);
  initial begin
    srcIn = '0;
    remoteSilence = 1'b0;
    // Outputs 0 to 7 are set up as alarm outputs, the rest are not.
    doAlarmCfg = 16'h00ff;
  end
  task automatic set_src(input int i, input logic signed [15:0] v,
    input logic signed [15:0] setPt, input logic signed [15:0] pct, input logic loopIn);
    @(posedge core_clk);
    srcIn[i] <= '{value: v, setPoint: setPt, outPct: pct, isLoop: loopIn};
  endtask
  task automatic silence(input int n);
    @(posedge core_clk);
    remoteSilence <= 1'b1;
    repeat (n) @(posedge core_clk);
    remoteSilence <= 1'b0;
  endtask
endmodule

// ==== pae_top.sv ====
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
// Functional notes
// - An alarm of type off never asserts.
// - Process alarms compare the input against absolute upper and lower levels.
// - Deviation levels are set point plus or minus the offsets.
// - Deviation and output percent types are refused on monitor inputs.
// - Output percent alarms compare the loop output percentage against levels.
// - Rate alarms trip when change exceeds the limit within the window.
// - A rate alarm clears only below the limit minus deadband.
// - Latching alarms hold until operator reset or remote silence.
// - Self-clearing alarms drop as soon as the condition ends.
// - An acknowledge during the condition clears the alarm when it ends.
// - With inhibit off the alarm asserts on crossing, after on-delay.
// - With inhibit on, the input must first be normal before tripping.
// - Inhibit rearms at power-up and on entering online operation.
// - The inhibit time limit cancels inhibit; zero keeps it indefinitely.
// - The condition must persist for the on-delay; zero is immediate.
// - A level alarm clears only after returning by the deadband.
// - An assigned digital output follows the alarm state when doAlarmCfg sets it up for alarms.
// - Upper-only uses upper level, lower-only lower, both uses both; rate alarms use the upper level on either side.
// - Each alarm selects one source; sources may be shared.
// - Thirty independent alarm channels are provided.
module pae_top #(
  parameter int NUM_ALARMS = pae_pkg::NUM_ALARMS,
  parameter int NUM_INPUTS = pae_pkg::NUM_INPUTS,
  parameter int SEC_CYCLES = pae_pkg::SEC_CYCLES,
  parameter int TICK_CYCLES = pae_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input pae_pkg::pae_src_t [NUM_INPUTS-1:0] srcIn,
  input wire logic remoteSilence,
  input wire logic [15:0] doAlarmCfg,
  output logic [15:0] digitalOut,
  output logic [NUM_ALARMS-1:0] alarmActive
);
  pae_pkg::pae_cfg_t cfg_q [NUM_ALARMS];
  pae_pkg::pae_cfg_t cfg_d [NUM_ALARMS];
  pae_pkg::pae_lim_t lim_q [NUM_ALARMS];
  pae_pkg::pae_lim_t lim_d [NUM_ALARMS];
  logic [NUM_ALARMS-1:0] act;
  logic [31:0] secCnt_q;
  logic [31:0] secCnt_d;
  logic [31:0] tickCnt_q;
  logic [31:0] tickCnt_d;
  logic secTick;
  logic evalTick;
  logic online_q;
  logic online_d;
  logic rearm;
  logic ackPulse_q;
  logic ackPulse_d;
  logic silence_q;
  logic [4:0] index_q;
  logic [4:0] index_d;
  pae_pkg::pae_cfg_t stCfg_q;
  pae_pkg::pae_cfg_t stCfg_d;
  pae_pkg::pae_lim_t stLim_q;
  pae_pkg::pae_lim_t stLim_d;
  logic awHeld_q;
  logic awHeld_d;
  logic wHeld_q;
  logic wHeld_d;
  logic [31:0] awAddr_q;
  logic [31:0] awAddr_d;
  logic [31:0] wData_q;
  logic [31:0] wData_d;
  logic bValid_d;
  logic [1:0] bResp_d;
  logic rValid_d;
  logic [31:0] rData_d;
  logic [1:0] rResp_d;
  logic [15:0] dOut_d;
  logic doWrite;
  logic [3:0] rdSel;
  pae_pkg::pae_src_t rdSrc;

  always_comb begin
    secTick = secCnt_q == 32'(SEC_CYCLES - 1);
    evalTick = tickCnt_q == 32'(TICK_CYCLES - 1) || secTick;
    secCnt_d = secTick ? '0 : secCnt_q + 32'd1;
    tickCnt_d = evalTick ? '0 : tickCnt_q + 32'd1;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_ALARMS; g++) begin : gCh
      pae_channel uCh (
        .core_clk(core_clk),
        .rst(rst),
        .secTick(secTick),
        .evalTick(evalTick),
        .rearm(rearm),
        .ack(ackPulse_q | silence_q),
        .cfg(cfg_q[g]),
        .lim(lim_q[g]),
        .src(srcIn[cfg_q[g].srcSel]),
        .active(act[g])
      );
    end
  endgenerate

  always_comb begin
    awHeld_d = awHeld_q;
    wHeld_d = wHeld_q;
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    bValid_d = s_axi_bvalid && !s_axi_bready;
    bResp_d = s_axi_bresp;
    online_d = online_q;
    ackPulse_d = 1'b0;
    index_d = index_q;
    stCfg_d = stCfg_q;
    stLim_d = stLim_q;
    cfg_d = cfg_q;
    lim_d = lim_q;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_d = 1'b1;
      wData_d = s_axi_wdata;
    end
    doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
    if (doWrite) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bValid_d = 1'b1;
      bResp_d = pae_pkg::RESP_OKAY;
      unique case (awAddr_q)
        pae_pkg::ADDR_CTRL: online_d = wData_q[pae_pkg::CTRL_ONLINE_BIT];
        pae_pkg::ADDR_ACK: ackPulse_d = wData_q[0];
        pae_pkg::ADDR_INDEX: index_d = wData_q[4:0];
        pae_pkg::ADDR_CFG: stCfg_d = pae_pkg::pae_cfg_t'(wData_q[$bits(pae_pkg::pae_cfg_t)-1:0]);
        pae_pkg::ADDR_LEVELS: begin
          stLim_d.lower = wData_q[15:0];
          stLim_d.upper = wData_q[31:16];
        end
        pae_pkg::ADDR_DBDLY: begin
          stLim_d.deadband = wData_q[15:0];
          stLim_d.onDelay = wData_q[30:16];
        end
        pae_pkg::ADDR_INHWIN: begin
          stLim_d.inhibitLimit = wData_q[14:0];
          stLim_d.rateWindow = wData_q[30:16];
        end
        pae_pkg::ADDR_COMMIT: begin
          if (32'(index_q) < 32'(NUM_ALARMS)) begin
            cfg_d[index_q] = stCfg_q;
            lim_d[index_q] = stLim_q;
          end
        end
        default: bResp_d = pae_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_comb begin
    rValid_d = s_axi_rvalid && !s_axi_rready;
    rData_d = s_axi_rdata;
    rResp_d = s_axi_rresp;
    rdSel = cfg_q[index_q < 5'(NUM_ALARMS) ? index_q : 5'd0].srcSel;
    rdSrc = srcIn[rdSel];
    if (s_axi_arvalid && s_axi_arready) begin
      rValid_d = 1'b1;
      rResp_d = pae_pkg::RESP_OKAY;
      rData_d = '0;
      unique case (s_axi_araddr)
        pae_pkg::ADDR_CTRL: rData_d = 32'(online_q);
        pae_pkg::ADDR_ACK: rData_d = '0;
        pae_pkg::ADDR_STATUS: rData_d = 32'(alarmActive);
        pae_pkg::ADDR_INDEX: rData_d = 32'(index_q);
        pae_pkg::ADDR_CFG: rData_d = 32'(stCfg_q);
        pae_pkg::ADDR_LEVELS: rData_d = {stLim_q.upper, stLim_q.lower};
        pae_pkg::ADDR_DBDLY: rData_d = {1'b0, stLim_q.onDelay, stLim_q.deadband};
        pae_pkg::ADDR_INHWIN: rData_d = {1'b0, stLim_q.rateWindow, 1'b0, stLim_q.inhibitLimit};
        pae_pkg::ADDR_COMMIT: rData_d = '0;
        pae_pkg::ADDR_VAL: rData_d = 32'(rdSrc.value);
        pae_pkg::ADDR_SP: rData_d = 32'(rdSrc.setPoint);
        pae_pkg::ADDR_OUTPCT: rData_d = 32'(rdSrc.outPct);
        pae_pkg::ADDR_ACTIVE: rData_d = 32'(act);
        default: rResp_d = pae_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_comb begin
    dOut_d = '0;
    for (int i = 0; i < NUM_ALARMS; i++) begin
      if (cfg_q[i].doEn && act[i] && doAlarmCfg[cfg_q[i].doSel]) begin
        dOut_d[cfg_q[i].doSel] = 1'b1;
      end
    end
  end

  assign rearm = online_d && !online_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      secCnt_q <= '0;
      tickCnt_q <= '0;
      online_q <= 1'b0;
      ackPulse_q <= 1'b0;
      silence_q <= 1'b0;
      index_q <= '0;
      stCfg_q <= '0;
      stLim_q <= '0;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= '0;
      digitalOut <= '0;
      alarmActive <= '0;
      for (int i = 0; i < NUM_ALARMS; i++) begin
        cfg_q[i] <= '0;
        lim_q[i] <= '0;
      end
    end else begin
      secCnt_q <= secCnt_d;
      tickCnt_q <= tickCnt_d;
      online_q <= online_d;
      ackPulse_q <= ackPulse_d;
      silence_q <= remoteSilence;
      index_q <= index_d;
      stCfg_q <= stCfg_d;
      stLim_q <= stLim_d;
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      s_axi_awready <= !awHeld_d && !(s_axi_awvalid && s_axi_awready) && !bValid_d;
      s_axi_wready <= !wHeld_d && !(s_axi_wvalid && s_axi_wready) && !bValid_d;
      s_axi_arready <= !rValid_d && !(s_axi_arvalid && s_axi_arready);
      s_axi_bvalid <= bValid_d;
      s_axi_bresp <= bResp_d;
      s_axi_rvalid <= rValid_d;
      s_axi_rdata <= rData_d;
      s_axi_rresp <= rResp_d;
      digitalOut <= dOut_d;
      alarmActive <= act;
      cfg_q <= cfg_d;
      lim_q <= lim_d;
    end
  end
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ns
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] awAddr = 32'h0, wData = 32'h0, arAddr = 32'h0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, remoteSilence;
  logic [1:0] bResp, rResp, rs;
  logic [31:0] rData, rd;
  logic [15:0] doAlarmCfg, digitalOut;
  logic [29:0] alarmActive;
  pae_pkg::pae_src_t [15:0] srcIn;
  pae_pkg::pae_cfg_t c;
  pae_pkg::pae_lim_t l;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int v;
  int p;

  pae_top #(.SEC_CYCLES(100), .TICK_CYCLES(10)) DUT (
    .core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .srcIn(srcIn), .remoteSilence(remoteSilence), .doAlarmCfg(doAlarmCfg),
    .digitalOut(digitalOut), .alarmActive(alarmActive)
  );
  pae_plant u_plant (.core_clk(core_clk), .srcIn(srcIn), .remoteSilence(remoteSilence),
    .doAlarmCfg(doAlarmCfg));

  always #5 core_clk = ~core_clk;

  task automatic conclude();
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bit awDone = 1'b0;
    bit wDone = 1'b0;
    @(posedge core_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    while (!(awDone && wDone)) begin
      @(negedge core_clk);
      awDone = awDone || (awValid && awReady);
      wDone = wDone || (wValid && wReady);
      @(posedge core_clk);
      if (awDone) awValid <= 1'b0;
      if (wDone) wValid <= 1'b0;
    end
    repeat ($urandom_range(0, 2)) @(posedge core_clk);
    bReady <= 1'b1;
    do @(negedge core_clk); while (bValid !== 1'b1);
    rs = bResp;
    @(posedge core_clk);
    bReady <= 1'b0;
  endtask

  task automatic rd_reg(input logic [31:0] a);
    @(posedge core_clk);
    arAddr <= a;
    arValid <= 1'b1;
    do @(negedge core_clk); while (arReady !== 1'b1);
    @(posedge core_clk);
    arValid <= 1'b0;
    repeat ($urandom_range(0, 2)) @(posedge core_clk);
    rReady <= 1'b1;
    do @(negedge core_clk); while (rValid !== 1'b1);
    rd = rData;
    rs = rResp;
    @(posedge core_clk);
    rReady <= 1'b0;
  endtask

  // Stages the shared settings and commits them to one alarm.
  task automatic prog(input int i);
    wr(pae_pkg::ADDR_INDEX, i);
    wr(pae_pkg::ADDR_CFG, {16'h0, c});
    wr(pae_pkg::ADDR_LEVELS, {l.upper, l.lower});
    wr(pae_pkg::ADDR_DBDLY, {1'b0, l.onDelay, l.deadband});
    wr(pae_pkg::ADDR_INHWIN, {1'b0, l.rateWindow, 1'b0, l.inhibitLimit});
    wr(pae_pkg::ADDR_COMMIT, 32'h1);
  endtask

  task automatic await(input int i, input logic e, input int n);
    int k = 0;
    while (alarmActive[i] !== e && k < n) begin
      @(negedge core_clk);
      k++;
    end
    check(alarmActive[i], e, "alarm did not reach the expected state");
  endtask

  task automatic hold(input int i, input logic e, input int n);
    logic seen = e;
    repeat (n) begin
      @(negedge core_clk);
      if (alarmActive[i] !== e) seen = alarmActive[i];
    end
    check(seen, e, "alarm left the expected state");
  endtask

  function automatic logic exp_trip(input pae_pkg::pae_cfg_t k, input int x, input int y);
    int s = (k.kind == pae_pkg::PAE_TYPE_OUTPCT) ? y : x;
    return (k.side[0] && s > 100) || (k.side[1] && s < 0);
  endfunction

  initial begin
    void'($urandom(32'h0372));
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    check(alarmActive, 32'h0, "alarms after reset");
    check(digitalOut, 32'h0, "outputs after reset");
    rd_reg(32'h0000_0040);
    check(rs, pae_pkg::RESP_SLVERR, "unmapped read");
    // Upper level alarm with deadband, a twin on the same input and a disabled one.
    c = '0;
    l = '0;
    c.kind = pae_pkg::PAE_TYPE_PROCESS;
    c.side = pae_pkg::PAE_SIDE_UPPER;
    c.doEn = 1'b1;
    c.doSel = 4'h2;
    l.upper = 16'sd100;
    l.deadband = 16'h5;
    prog(0);
    c.doSel = 4'h9;
    prog(29);
    c.kind = pae_pkg::PAE_TYPE_OFF;
    prog(8);
    u_plant.set_src(0, 16'sd120, 16'sd0, 16'sd0, 1'b1);
    await(0, 1'b1, 100);
    await(29, 1'b1, 30);
    hold(8, 1'b0, 40);
    check(digitalOut, 32'h4, "alarm outputs");
    rd_reg(pae_pkg::ADDR_STATUS);
    check(rd, 32'h2000_0001, "status word");
    rd_reg(pae_pkg::ADDR_ACTIVE);
    check(rd, 32'h2000_0001, "raw active word");
    u_plant.set_src(0, 16'sd97, 16'sd0, 16'sd0, 1'b1);
    hold(0, 1'b1, 60);
    u_plant.set_src(0, 16'sd90, 16'sd0, 16'sd0, 1'b1);
    await(0, 1'b0, 100);
    // Latching: operator reset, then remote silence while the condition holds.
    c.kind = pae_pkg::PAE_TYPE_PROCESS;
    c.doSel = 4'h2;
    c.latching = 1'b1;
    prog(0);
    u_plant.set_src(0, 16'sd120, 16'sd0, 16'sd0, 1'b1);
    await(0, 1'b1, 100);
    u_plant.set_src(0, 16'sd50, 16'sd0, 16'sd0, 1'b1);
    hold(0, 1'b1, 60);
    wr(pae_pkg::ADDR_ACK, 32'h1);
    await(0, 1'b0, 100);
    u_plant.set_src(0, 16'sd120, 16'sd0, 16'sd0, 1'b1);
    await(0, 1'b1, 100);
    u_plant.silence(30);
    hold(0, 1'b1, 30);
    u_plant.set_src(0, 16'sd50, 16'sd0, 16'sd0, 1'b1);
    await(0, 1'b0, 100);
    // On-delay of two seconds.
    c.latching = 1'b0;
    c.doEn = 1'b0;
    c.srcSel = 4'h6;
    l.deadband = 16'h0;
    l.onDelay = 15'd2;
    prog(2);
    u_plant.set_src(6, 16'sd120, 16'sd0, 16'sd0, 1'b1);
    hold(2, 1'b0, 90);
    await(2, 1'b1, 400);
    // Inhibit without and with a two second limit, rearmed by going online.
    l.onDelay = 15'd0;
    c.inhibitEn = 1'b1;
    c.srcSel = 4'h3;
    u_plant.set_src(3, 16'sd120, 16'sd0, 16'sd0, 1'b1);
    u_plant.set_src(7, 16'sd120, 16'sd0, 16'sd0, 1'b1);
    wr(pae_pkg::ADDR_CTRL, 32'h0);
    prog(4);
    c.srcSel = 4'h7;
    l.inhibitLimit = 15'd2;
    prog(9);
    wr(pae_pkg::ADDR_CTRL, 32'h1);
    check(rs, pae_pkg::RESP_OKAY, "online write response");
    hold(9, 1'b0, 90);
    await(9, 1'b1, 400);
    hold(4, 1'b0, 300);
    u_plant.set_src(3, 16'sd50, 16'sd0, 16'sd0, 1'b1);
    hold(4, 1'b0, 40);
    u_plant.set_src(3, 16'sd120, 16'sd0, 16'sd0, 1'b1);
    await(4, 1'b1, 100);
    // Deviation window follows the set point; deviation and output percent alarms on a monitor input never trip.
    c = '0;
    l = '0;
    c.kind = pae_pkg::PAE_TYPE_DEVIATION;
    c.side = pae_pkg::PAE_SIDE_BOTH;
    c.srcSel = 4'h1;
    l.upper = 16'sd20;
    l.lower = 16'sd20;
    u_plant.set_src(1, 16'sd230, 16'sd200, 16'sd0, 1'b1);
    prog(5);
    await(5, 1'b1, 100);
    u_plant.set_src(1, 16'sd230, 16'sd240, 16'sd0, 1'b1);
    await(5, 1'b0, 100);
    u_plant.set_src(1, 16'sd210, 16'sd240, 16'sd0, 1'b1);
    await(5, 1'b1, 100);
    c.srcSel = 4'h4;
    prog(6);
    c.kind = pae_pkg::PAE_TYPE_OUTPCT;
    prog(7);
    u_plant.set_src(4, 16'sd500, 16'sd0, 16'sd500, 1'b0);
    hold(6, 1'b0, 200);
    hold(7, 1'b0, 10);
    // Rise-only rate alarm with a one minute window.
    c.kind = pae_pkg::PAE_TYPE_RATE;
    c.side = pae_pkg::PAE_SIDE_UPPER;
    c.srcSel = 4'h2;
    l.deadband = 16'h5;
    l.rateWindow = 15'd1;
    prog(3);
    hold(3, 1'b0, 300);
    u_plant.set_src(2, 16'sd50, 16'sd0, 16'sd0, 1'b1);
    await(3, 1'b1, 400);
    await(3, 1'b0, 7000);
    u_plant.set_src(2, 16'sd0, 16'sd0, 16'sd0, 1'b1);
    hold(3, 1'b0, 400);
    // Random levels against process and output percent alarms.
    c = '0;
    l = '0;
    c.srcSel = 4'h5;
    l.upper = 16'sd100;
    for (int n = 0; n < 12; n++) begin
      u_plant.set_src(5, 16'sd50, 16'sd0, 16'sd50, 1'b1);
      await(1, 1'b0, 100);
      c.kind = ($urandom_range(0, 1) == 0) ? pae_pkg::PAE_TYPE_PROCESS : pae_pkg::PAE_TYPE_OUTPCT;
      c.side = pae_pkg::pae_side_t'($urandom_range(1, 3));
      v = int'($urandom_range(0, 200)) - 50;
      p = int'($urandom_range(0, 200)) - 50;
      if (v inside {[-1:1], [99:101]}) v = 50;
      if (p inside {[-1:1], [99:101]}) p = 50;
      prog(1);
      u_plant.set_src(5, 16'(v), 16'sd0, 16'(p), 1'b1);
      await(1, exp_trip(c, v, p), 100);
      hold(1, exp_trip(c, v, p), 30);
    end
    conclude();
  end
endmodule
